// *** spi_diag_pkg.sv ***
package spi_diag_pkg;

  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] OPCODE_LEN = 5'h08;
  localparam logic [3:0] IDX_MSB = 4'hF;
  localparam logic [3:0] IDX_FIRST_DRIVEN = 4'hD;

  // Opcodes in the upper byte of the input frame
  localparam logic [7:0] OP_READ_DIAG = 8'h09;
  localparam logic [7:0] OP_READ_CFG = 8'h28;

  // Fixed upper response bits below the two undriven ones
  localparam logic [4:0] VERIFY_PATTERN = 5'h15;
  localparam logic [1:0] UNDRIVEN_BITS = 2'h0;

  // Temperature state codes and reset values of the readback fields
  localparam logic [1:0] TEMP_STATE_COOL = 2'h3;
  localparam logic [1:0] TEMP_STATE_LIMIT = 2'h2;
  localparam logic [1:0] TEMP_STATE_HOT = 2'h0;
  localparam logic LOCKOUT_RESET = 1'b1;
  localparam logic FRAME_ERR_RESET = 1'b0;

  // Idle levels of the serial pins: clock low, select high, data high
  localparam logic [2:0] PIN_IDLE = 3'h3;

  // Per-output fault codes
  localparam logic [1:0] CODE_SHORT_VS = 2'h1;
  localparam logic [1:0] CODE_SHORT_GND = 2'h2;
  localparam logic [1:0] CODE_NORMAL = 2'h3;
  localparam logic [1:0] CODE_ZERO = 2'h0;

  // Fault events and levels from the protection logic, same clock
  typedef struct packed {
    logic undervoltage;
    logic shorted_load;
    logic out_a_short_vs;
    logic out_a_short_gnd;
    logic out_b_short_vs;
    logic out_b_short_gnd;
    logic open_load;
    logic current_limit_event;
    logic tj_above_limit;
    logic tj_above_shutdown;
    logic outputs_enabled;
    logic clear_by_enable;
    logic lockout_set;
    logic lockout_release;
  } fault_in_t;

  // Current configuration held by the write logic
  typedef struct packed {
    logic disable_pin_function;
    logic pump_power_sel;
    logic out_a_enable;
    logic out_b_enable;
    logic [1:0] ilim_sel;
  } cfg_in_t;

endpackage : spi_diag_pkg

// *** pin_sync.sv ***
module pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // Two flops per line, only the second is read
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1_reg <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule : pin_sync

// *** spi_config_diag_readback.sv ***
// How it works
// - Read-diagnostic opcode 0x09 returns diagnostic byte in the same frame.
// - After a valid read-diagnostic frame, all latched diagnostic entries are cleared.
// - Write-config frames also return diagnostic byte but clear nothing.
// - Every response: top two bits undriven, 10101 on 13:9, error flag at 8.
// - Error flag reads 0 after a valid frame, latches 1 on a bad frame.
// - Temperature state 11 cool, 10 in limit band, 00 above shutdown; latched.
// - Config byte echoes two-bit current-limit selection, default 10.
// - Output-control bit is 1 only when both output enables are set.
// - Config byte reports lockout (default 1), pump power and pin function.
// - Low nibble codes: 01 short supply, 10 short ground, 11 normal; open load reads 00/11.
// - 11/00 pattern shows shorted load; all zero shows undervoltage or power-on.
// - Current-limit flag latches 0 on overcurrent, reads 1 otherwise.
// - Limit-reduction and overtemperature flags latch 0 on their thresholds.
// - Enable status bit follows present output enable state, unlatched.
// - Higher-priority faults overwrite lower; data returns after undervoltage.
// - Clearing discards overwritten data; codes read zero after power-on reset.
// - Config-read opcode 0x28 answers configuration in the lower byte.
module spi_config_diag_readback
  import spi_diag_pkg::*;
#(
  parameter logic [1:0] WRITE_CFG_PREFIX = 2'h3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic si_pin,
  output logic so_out,
  output logic so_oe_n,
  input wire fault_in_t fault_in,
  input wire cfg_in_t cfg_in,
  output logic frame_error_flag,
  output logic diag_cleared
);

  logic sclk_s;
  logic cs_n_s;
  logic si_s;

  // Synchroniser resets to the idle pin levels, so no false edge follows reset
  pin_sync #(.WIDTH(3), .RESET_VALUE(PIN_IDLE)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({sclk_pin, cs_n_pin, si_pin}),
    .sync_out({sclk_s, cs_n_s, si_s})
  );

  logic sclk_d_reg;
  logic cs_n_d_reg;
  logic [CNT_W-1:0] rx_cnt_reg;
  logic [7:0] opcode_reg;
  logic [FRAME_BITS-1:0] tx_reg;
  logic [3:0] bit_idx_reg;
  logic frame_err_reg;

  // Latched fault state
  logic shorted_reg;
  logic a_vs_reg;
  logic a_gnd_reg;
  logic b_vs_reg;
  logic b_gnd_reg;
  logic open_reg;
  logic por_reg;
  logic ilim_hit_n_reg;
  logic reduced_n_reg;
  logic hot_n_reg;
  logic [1:0] temp_state_reg;
  logic lockout_reg;

  // Edge detection on synchronised pins
  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire cs_start = ~cs_n_s & cs_n_d_reg;
  wire cs_end = cs_n_s & ~cs_n_d_reg;
  wire active = ~cs_n_s;

  // Frame judgement and opcode decode
  wire frame_valid = (rx_cnt_reg == FRAME_LEN);
  wire op_done = active & sclk_fall & (rx_cnt_reg == OPCODE_LEN - 5'h01);
  wire [7:0] opcode_now = {opcode_reg[6:0], si_s};
  wire is_diagnostic_status = (opcode_reg == OP_READ_DIAG);
  wire diag_read_clear = cs_end & frame_valid & is_diagnostic_status;
  wire diag_clear = diag_read_clear | fault_in.clear_by_enable;

  // Priority encoding of per-output codes
  wire any_short = a_vs_reg | a_gnd_reg | b_vs_reg | b_gnd_reg;
  wire [1:0] a_code_raw = a_vs_reg ? CODE_SHORT_VS :
                          a_gnd_reg ? CODE_SHORT_GND : CODE_NORMAL;
  wire [1:0] b_code_raw = b_vs_reg ? CODE_SHORT_VS :
                          b_gnd_reg ? CODE_SHORT_GND : CODE_NORMAL;
  wire zero_codes = fault_in.undervoltage | por_reg;
  wire use_shorted = shorted_reg;
  wire use_open = open_reg & ~any_short;
  wire [1:0] out_a_code = zero_codes ? CODE_ZERO : use_shorted ? CODE_ZERO :
                          use_open ? CODE_NORMAL : a_code_raw;
  wire [1:0] out_b_code = zero_codes ? CODE_ZERO : use_shorted ? CODE_NORMAL :
                          use_open ? CODE_ZERO : b_code_raw;

  // Response lower bytes
  wire outputs_cfg_on = cfg_in.out_a_enable & cfg_in.out_b_enable;
  wire [7:0] diag_byte = {fault_in.outputs_enabled, hot_n_reg, reduced_n_reg, ilim_hit_n_reg,
                          out_b_code, out_a_code};
  wire [7:0] cfg_byte = {cfg_in.disable_pin_function, cfg_in.pump_power_sel,
                         outputs_cfg_on, lockout_reg, cfg_in.ilim_sel,
                         temp_state_reg};
  wire sel_diag = (opcode_now == OP_READ_DIAG) |
                  (opcode_now[7:6] == WRITE_CFG_PREFIX);
  wire sel_cfg = (opcode_now == OP_READ_CFG);
  wire [7:0] low_byte = sel_diag ? diag_byte : sel_cfg ? cfg_byte : 8'h00;
  wire [7:0] high_byte = {UNDRIVEN_BITS, VERIFY_PATTERN, frame_err_reg};

  // Temperature state: keep the worst state seen until cleared
  wire [1:0] temp_seen = fault_in.tj_above_shutdown ? TEMP_STATE_HOT :
                         fault_in.tj_above_limit ? TEMP_STATE_LIMIT : TEMP_STATE_COOL;
  wire [1:0] temp_base = diag_clear ? TEMP_STATE_COOL : temp_state_reg;
  wire [1:0] temp_state_next = (temp_seen < temp_base) ? temp_seen : temp_base;

  // Pin edge history
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  // Receive counter and opcode shifter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_cnt_reg <= '0;
      opcode_reg <= 8'h00;
    end else if (cs_start) begin
      rx_cnt_reg <= '0;
      opcode_reg <= 8'h00;
    end else if (active & sclk_fall) begin
      if (rx_cnt_reg != 5'h1F)
        rx_cnt_reg <= rx_cnt_reg + 5'h01;
      if (rx_cnt_reg < OPCODE_LEN)
        opcode_reg <= opcode_now;
    end
  end

  // Response word: upper byte at frame start, lower byte after opcode
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_reg <= '0;
    end else if (cs_start) begin
      tx_reg <= {high_byte, 8'h00};
    end else if (op_done) begin
      tx_reg[7:0] <= low_byte;
    end
  end

  // Serial out, changes on sclk rise, upper two bits undriven
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bit_idx_reg <= IDX_MSB;
      so_out <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (cs_start | ~active) begin
      bit_idx_reg <= IDX_MSB;
      so_out <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (sclk_rise) begin
      so_out <= tx_reg[bit_idx_reg];
      so_oe_n <= (bit_idx_reg > IDX_FIRST_DRIVEN);
      bit_idx_reg <= bit_idx_reg - 4'h1;
    end
  end

  // Frame error flag, judged at each frame end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      frame_err_reg <= FRAME_ERR_RESET;
    end else if (cs_end) begin
      frame_err_reg <= ~frame_valid;
    end
  end

  // Latched short and open entries, set wins over clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      shorted_reg <= 1'b0;
      a_vs_reg <= 1'b0;
      a_gnd_reg <= 1'b0;
      b_vs_reg <= 1'b0;
      b_gnd_reg <= 1'b0;
      open_reg <= 1'b0;
    end else begin
      shorted_reg <= fault_in.shorted_load | (shorted_reg & ~diag_clear);
      a_vs_reg <= fault_in.out_a_short_vs | (a_vs_reg & ~diag_clear);
      a_gnd_reg <= fault_in.out_a_short_gnd | (a_gnd_reg & ~diag_clear);
      b_vs_reg <= fault_in.out_b_short_vs | (b_vs_reg & ~diag_clear);
      b_gnd_reg <= fault_in.out_b_short_gnd | (b_gnd_reg & ~diag_clear);
      open_reg <= fault_in.open_load | (open_reg & ~diag_clear);
    end
  end

  // Power-on marker and active-low latched flags
  always_ff @(posedge clk) begin
    if (!resetn) begin
      por_reg <= 1'b1;
      ilim_hit_n_reg <= 1'b1;
      reduced_n_reg <= 1'b1;
      hot_n_reg <= 1'b1;
    end else begin
      por_reg <= por_reg & ~diag_clear;
      ilim_hit_n_reg <= ~fault_in.current_limit_event & (ilim_hit_n_reg | diag_clear);
      reduced_n_reg <= ~fault_in.tj_above_limit & (reduced_n_reg | diag_clear);
      hot_n_reg <= ~fault_in.tj_above_shutdown & (hot_n_reg | diag_clear);
    end
  end

  // Temperature state and lockout
  always_ff @(posedge clk) begin
    if (!resetn) begin
      temp_state_reg <= TEMP_STATE_COOL;
      lockout_reg <= LOCKOUT_RESET;
    end else begin
      temp_state_reg <= temp_state_next;
      lockout_reg <= fault_in.lockout_set | (lockout_reg & ~fault_in.lockout_release);
    end
  end

  // Status outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      frame_error_flag <= FRAME_ERR_RESET;
      diag_cleared <= 1'b0;
    end else begin
      frame_error_flag <= cs_end ? ~frame_valid : frame_err_reg;
      diag_cleared <= diag_read_clear;
    end
  end

endmodule : spi_config_diag_readback

// *** spi_config_diag_readback_monitor.sv ***
module spi_config_diag_readback_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic so_out,
  input wire logic so_oe_n,
  input wire logic frame_error_flag,
  input wire logic diag_cleared
);
  timeunit 1ns;
  timeprecision 100ps;
  // Every check on the system clock, idle in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Output pin released between frames and for eight cycles after select falls
  a_idle_undriven: assert property (cs_n_pin [*6] |-> so_oe_n)
    else $error("so driven outside frame");
  a_head_undriven: assert property ($fell(cs_n_pin) |=> so_oe_n [*8])
    else $error("so driven on head bits");
  a_drive_on_rise: assert property ($fell(so_oe_n) |-> sclk_pin && !cs_n_pin)
    else $error("so drive start off a rising edge");
  // Response data only moves after a serial clock rise
  a_data_on_rise: assert property (!so_oe_n && $changed(so_out) |-> sclk_pin)
    else $error("so changed with serial clock low");
  // Diagnostic clear is a lone pulse after a good frame
  a_clear_one_pulse: assert property (diag_cleared |=> !diag_cleared)
    else $error("clear pulse too long");
  a_clear_frame_end: assert property (diag_cleared |-> cs_n_pin)
    else $error("clear inside a frame");
  a_clear_only_valid: assert property (diag_cleared |-> !frame_error_flag)
    else $error("clear after a bad frame");
  a_flag_frame_end: assert property ($changed(frame_error_flag) |-> cs_n_pin)
    else $error("error flag moved inside a frame");
endmodule : spi_config_diag_readback_monitor

// *** spi_host_model.sv ***
module spi_host_model (
  input wire logic clk,
  output logic sclk_pin,
  output logic cs_n_pin,
  output logic si_pin,
  input wire logic so_out,
  input wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle: clock low, select high, data at its pull-up
  initial begin
    sclk_pin = 1'h0;
    cs_n_pin = 1'h1;
    si_pin = 1'h1;
  end
  // Mode 1 frame, 80 ns clock; nfall below 16 makes a broken frame
  task automatic xfer(input logic [15:0] cmd, input int nfall, output logic [15:0] resp);
    resp = 16'hZZZZ;
    @(posedge clk) cs_n_pin <= 1'h0;
    repeat (4) @(posedge clk);
    for (int i = 15; i > 15 - nfall; i--) begin
      sclk_pin <= 1'h1;
      si_pin <= cmd[i];
      repeat (8) @(posedge clk);
      sclk_pin <= 1'h0;
      resp[i] = so_oe_n ? 1'hZ : so_out;
      repeat (8) @(posedge clk);
    end
    cs_n_pin <= 1'h1;
    si_pin <= 1'h1;
    repeat (12) @(posedge clk);
  endtask : xfer
endmodule : spi_host_model

// *** spi_config_diag_readback_test.sv ***
module spi_config_diag_readback_test import spi_diag_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] op; logic [13:0] flt; logic [5:0] cfg; logic [7:0] low;} row_t;
  logic clk = 1'h0, resetn = 1'h0, clr_seen = 1'h0;
  logic sclk_pin, cs_n_pin, si_pin, so_out, so_oe_n, frame_error_flag, diag_cleared;
  logic [15:0] resp;
  fault_in_t fault_in = '0;
  cfg_in_t cfg_in = 6'h0E;
  int bad_count = 0, tests_run = 0;
  // Opcode, fault pulses, config, expected lower byte
  row_t rows [23] = '{{8'h28,14'h0008,6'h0E,8'h3B}, {8'h09,14'h0008,6'h0E,8'hF0},
    {8'h09,14'h0008,6'h0E,8'hFF}, {8'hC0,14'h0808,6'h0E,8'hFD}, {8'h09,14'h0008,6'h0E,8'hFD},
    {8'h09,14'h0008,6'h0E,8'hFF}, {8'h09,14'h0108,6'h0E,8'hFB}, {8'h09,14'h1408,6'h0E,8'hFC},
    {8'h09,14'h0088,6'h0E,8'hF3}, {8'h09,14'h0888,6'h0E,8'hFD}, {8'hC0,14'h2208,6'h0E,8'hF0},
    {8'hC0,14'h0008,6'h0E,8'hF7}, {8'h09,14'h0008,6'h0E,8'hF7}, {8'h09,14'h0040,6'h0E,8'h6F},
    {8'h28,14'h0029,6'h0E,8'h2A}, {8'h28,14'h0018,6'h0E,8'h28}, {8'h09,14'h0008,6'h0E,8'h9F},
    {8'h28,14'h0008,6'h35,8'hC7}, {8'h28,14'h000A,6'h0F,8'h3F}, {8'h28,14'h0008,6'h0C,8'h33},
    {8'h55,14'h0008,6'h0E,8'h00}, {8'hC0,14'h0408,6'h0E,8'hFE}, {8'hC0,14'h000C,6'h0E,8'hFF}};
  always #2.5 clk = ~clk;
  always @(posedge clk) if (diag_cleared === 1'h1) clr_seen <= 1'h1;
  spi_config_diag_readback i_spi_config_diag_readback (.clk(clk), .resetn(resetn),
    .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .si_pin(si_pin), .so_out(so_out),
    .so_oe_n(so_oe_n), .fault_in(fault_in), .cfg_in(cfg_in),
    .frame_error_flag(frame_error_flag), .diag_cleared(diag_cleared));
  spi_host_model i_spi_host_model (.clk(clk), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .si_pin(si_pin), .so_out(so_out), .so_oe_n(so_oe_n));
  function automatic logic [15:0] frame_of(input logic err, input logic [7:0] low);
    return {2'hZ, VERIFY_PATTERN, err, low};
  endfunction : frame_of
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  task automatic summarize;
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Fault pulses, then only undervoltage and enable levels stay
  task automatic pace(input logic [13:0] f);
    fault_in <= f;
    repeat (4) @(posedge clk);
    fault_in <= f & 14'h2008;
    @(posedge clk);
  endtask : pace
  task automatic run(input logic [7:0] op, input int nfall, input logic [15:0] exp);
    clr_seen = 1'h0;
    i_spi_host_model.xfer({op, 8'h5A}, nfall, resp);
    if (nfall == 16) check_word("response", exp, resp);
    check_bit("clear pulse", op == OP_READ_DIAG && nfall == 16, clr_seen);
  endtask : run
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    repeat (3) @(posedge clk);
    foreach (rows[k]) begin
      cfg_in <= rows[k].cfg;
      pace(rows[k].flt);
      run(rows[k].op, 16, frame_of(1'h0, rows[k].low));
    end
    // Broken frame keeps latched data and raises the error flag
    pace(14'h0808);
    run(OP_READ_DIAG, 15, 16'h0000);
    check_bit("error flag", 1'h1, frame_error_flag);
    run(OP_READ_DIAG, 16, frame_of(1'h1, 8'hFD));
    run(OP_READ_DIAG, 16, frame_of(1'h0, 8'hFF));
    // Reset in mid-run, after a bad frame, restores power-on state
    pace(14'h0808);
    run(OP_READ_DIAG, 15, 16'h0000);
    resetn <= 1'h0;
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    repeat (3) @(posedge clk);
    check_bit("error flag", 1'h0, frame_error_flag);
    check_bit("output enable", 1'h1, so_oe_n);
    run(OP_READ_CFG, 16, frame_of(1'h0, 8'h3B));
    run(OP_READ_DIAG, 16, frame_of(1'h0, 8'hF0));
    summarize;
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    summarize;
  end
endmodule : spi_config_diag_readback_test
bind spi_config_diag_readback spi_config_diag_readback_monitor i_mon (.clk(clk), .resetn(resetn),
  .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .so_out(so_out), .so_oe_n(so_oe_n),
  .frame_error_flag(frame_error_flag), .diag_cleared(diag_cleared));
